// [design/sad_decoder.sv]
/*
  System address decoder: one-cycle registered region/window decode with
  boot remap, plus the interrupt source and clock gate index map.
  Assumes request address and remap command come from logic on SYS_CLK;
  the boot select and external interrupt pins are asynchronous.
  Every output is a bit of one state register, so targets see clean,
  glitch-free selects; the price is one cycle of decode latency.
  RESETN is synchronous and folded into the next-state logic.
*/
`timescale 1ns/10ps
module sad_decoder (
  // clock and synchronous reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // decode request, same clock
  input  wire logic        REQ_VALID,
  input  wire logic [31:0] REQ_ADDR,
  // boot map control; the select pin is asynchronous
  input  wire logic        REMAP_CMD,
  input  wire logic        BOOT_MEMORY_SELECT,
  // system interrupt lines, combined onto one index
  input  wire logic        MEM_CTRL_IRQ,
  input  wire logic        DEBUG_UNIT_IRQ,
  input  wire logic        SYS_TIMER_IRQ,
  input  wire logic        RTC_IRQ,
  input  wire logic        POWER_MGR_IRQ,
  // interrupt pins, synchronised before use
  input  wire logic        FAST_INTERRUPT,
  input  wire logic [6:0]  EXTERNAL_INTERRUPT,
  // peripheral interrupt lines, same clock
  input  wire logic [3:0]  PARALLEL_IO_IRQ,
  input  wire logic [3:0]  SERIAL_PORT_IRQ,
  input  wire logic        CARD_INTERFACE_IRQ,
  input  wire logic        USB_DEVICE_IRQ,
  input  wire logic        TWO_WIRE_IRQ,
  input  wire logic        SPI_IRQ,
  input  wire logic [2:0]  SYNC_SERIAL_IRQ,
  input  wire logic [5:0]  TIMER_CHANNEL_IRQ,
  input  wire logic        USB_HOST_IRQ,
  input  wire logic        ETHERNET_IRQ,
  // clock enable requests, one per index
  input  wire logic [31:0] CLOCK_GATE_REQ,
  // decode answer, one cycle after the request
  output logic             SEL_VALID,
  output logic [7:0]       EXT_CHIP_SELECT,
  output logic             ROM_SELECT,
  output logic             SRAM_SELECT,
  output logic             USB_HOST_SELECT,
  output logic             PERIPH_SELECT,
  output logic             ABORT,
  output logic [31:0]      TARGET_ADDR,
  // boot map state
  output logic             REMAP_STATE,
  output logic             BOOT_FROM_ROM,
  // interrupt and clock gate map
  output logic             COMBINED_SYSTEM_INTERRUPT,
  output logic [31:0]      INTERRUPT_SOURCES,
  output logic [31:0]      PERIPH_CLOCK_ENABLE
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    // boot select and interrupt pin synchronisers and boot map
    logic        bms_s1;
    logic        bms_s2;
    logic        boot_rom;
    logic        remap;
    logic [7:0]  ext_s1;
    logic [7:0]  ext_s2;
    // decode answer
    logic        sel_valid;
    logic [7:0]  ext_cs;
    logic        rom_sel;
    logic        sram_sel;
    logic        usb_sel;
    logic        periph_sel;
    logic        abort;
    logic [31:0] target_addr;
    // interrupt and clock gate map
    logic        sys_irq;
    logic [31:0] irq_src;
    logic [31:0] clk_en;
  } sad_state_s;

  // state register and its next value
  sad_state_s           s_r;
  sad_state_s           s_nxt;
  // decode results, settled before the clock edge
  sad_pkg::sad_target_e tgt;
  logic [3:0]           region;
  logic [7:0]           window;
  logic [19:0]          win_off;
  logic [31:0]          mapped;
  // interrupt index map before the output register
  logic [31:0]          src;

  // ****************************************************************
  // address decode
  // ****************************************************************

  // first stage by region, second stage by 1 MB window inside region 0;
  // region 0 is the only one whose answer depends on state (remap, boot)
  always_comb begin
    region  = REQ_ADDR[sad_pkg::REGION_MSB:sad_pkg::REGION_LSB];
    window  = REQ_ADDR[sad_pkg::WIN_MSB:sad_pkg::WIN_LSB];
    win_off = REQ_ADDR[sad_pkg::WIN_LSB-1:0];
    tgt     = sad_sysdec_none();
    mapped  = REQ_ADDR;
    if (region == sad_pkg::REGION_INTERNAL) begin
      case (window)
        sad_pkg::WIN_ALIAS: begin
          // zero alias follows the remap flag: SRAM after; before, boot ROM if boot_rom is set, else abort
          if (s_r.remap) begin
            tgt    = (win_off < sad_pkg::SRAM_SIZE) ? sad_pkg::TGT_SRAM
                                                     : sad_pkg::TGT_ABORT;
            mapped = sad_pkg::SRAM_BASE | {12'h000, win_off};
          end else if (s_r.boot_rom) begin
            tgt    = (win_off < sad_pkg::ROM_SIZE) ? sad_pkg::TGT_ROM
                                                    : sad_pkg::TGT_ABORT;
            mapped = sad_pkg::ROM_BASE | {12'h000, win_off};
          end else begin
            tgt    = sad_pkg::TGT_ABORT;
          end
        end
        // fixed windows answer whatever the remap state
        sad_pkg::WIN_ROM: begin
          tgt = (win_off < sad_pkg::ROM_SIZE) ? sad_pkg::TGT_ROM
                                               : sad_pkg::TGT_ABORT;
        end
        sad_pkg::WIN_SRAM: begin
          tgt = (win_off < sad_pkg::SRAM_SIZE) ? sad_pkg::TGT_SRAM
                                                : sad_pkg::TGT_ABORT;
        end
        sad_pkg::WIN_USB_HOST: begin
          tgt = sad_pkg::TGT_USB;
        end
        // unused windows inside region 0
        default: begin
          tgt = sad_pkg::TGT_ABORT;
        end
      endcase
    end else if (region >= sad_pkg::REGION_EXT_LO && region <= sad_pkg::REGION_EXT_HI) begin
      // chip select number is picked when the answer is registered
      tgt = sad_pkg::TGT_EXT;
    end else if (region == sad_pkg::REGION_PERIPH) begin
      tgt = sad_pkg::TGT_PERIPH;
    end else begin
      // unused regions: the master gets an abort, no target is woken
      tgt = sad_pkg::TGT_ABORT;
    end
  end

  // idle target, kept as a function so the default reads in one place;
  // every decode branch overwrites it, so it never reaches the selects
  function automatic sad_pkg::sad_target_e sad_sysdec_none();
    return sad_pkg::TGT_NONE;
  endfunction : sad_sysdec_none

  // ****************************************************************
  // interrupt source map
  // ****************************************************************

  // every index fixed in place; the same index also picks the clock gate;
  // pins arrive through the synchroniser, on-chip lines other than the registered system line are taken directly
  always_comb begin
    src                                 = 32'h0000_0000;
    // low indices: fast pin and the combined system line
    src[sad_pkg::IDX_FAST]              = s_r.ext_s2[0];
    src[sad_pkg::IDX_SYSTEM]            = s_r.sys_irq;
    // four parallel I/O banks and four serial ports
    for (int i = 0; i < 4; i++) begin
      src[sad_pkg::IDX_PARALLEL_IO + i] = PARALLEL_IO_IRQ[i];
      src[sad_pkg::IDX_SERIAL + i]      = SERIAL_PORT_IRQ[i];
    end
    // single on-chip peripherals, then the serial and timer banks
    src[sad_pkg::IDX_CARD]              = CARD_INTERFACE_IRQ;
    src[sad_pkg::IDX_USB_DEVICE]        = USB_DEVICE_IRQ;
    src[sad_pkg::IDX_TWO_WIRE]          = TWO_WIRE_IRQ;
    src[sad_pkg::IDX_SPI]               = SPI_IRQ;
    for (int i = 0; i < 3; i++) begin
      src[sad_pkg::IDX_SYNC_SERIAL + i] = SYNC_SERIAL_IRQ[i];
    end
    for (int i = 0; i < 6; i++) begin
      src[sad_pkg::IDX_TIMER + i]       = TIMER_CHANNEL_IRQ[i];
    end
    src[sad_pkg::IDX_USB_HOST]          = USB_HOST_IRQ;
    src[sad_pkg::IDX_ETHERNET]          = ETHERNET_IRQ;
    // top indices: the seven external pins, in order
    for (int i = 0; i < 7; i++) begin
      src[sad_pkg::IDX_EXTERNAL + i]    = s_r.ext_s2[i+1];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  // decode results last one cycle; an idle cycle clears every select
  // so a target never sees a stale select from an earlier request
  always_comb begin
    s_nxt           = s_r;
    // synchronisers shift every cycle, reset or not
    s_nxt.bms_s1    = BOOT_MEMORY_SELECT;
    s_nxt.bms_s2    = s_r.bms_s1;
    s_nxt.ext_s1    = {EXTERNAL_INTERRUPT, FAST_INTERRUPT};
    s_nxt.ext_s2    = s_r.ext_s1;

    // answers default to idle; a taken request sets exactly one
    s_nxt.sel_valid = REQ_VALID;
    s_nxt.ext_cs    = 8'h00;
    s_nxt.rom_sel   = 1'b0;
    s_nxt.sram_sel  = 1'b0;
    s_nxt.usb_sel   = 1'b0;
    s_nxt.periph_sel = 1'b0;
    s_nxt.abort     = 1'b0;
    if (REQ_VALID) begin
      s_nxt.target_addr = mapped;
      case (tgt)
        sad_pkg::TGT_EXT: begin
          // region n drives chip select n-1
          s_nxt.ext_cs = 8'h01 << (region - sad_pkg::REGION_EXT_LO);
        end
        sad_pkg::TGT_ROM: begin
          s_nxt.rom_sel = 1'b1;
        end
        sad_pkg::TGT_SRAM: begin
          s_nxt.sram_sel = 1'b1;
        end
        sad_pkg::TGT_USB: begin
          s_nxt.usb_sel = 1'b1;
        end
        sad_pkg::TGT_PERIPH: begin
          s_nxt.periph_sel = 1'b1;
        end
        sad_pkg::TGT_ABORT: begin
          s_nxt.abort = 1'b1;
        end
        default: begin
          s_nxt.abort = 1'b0;
        end
      endcase
    end
    // remap is one way until the next reset; the request in the same
    // cycle still decodes with the old map
    if (REMAP_CMD) begin
      s_nxt.remap = 1'b1;
    end
    // system interrupt is registered once so the output stays a flop;
    // index 1 therefore lags the combined line by one more cycle
    s_nxt.sys_irq = MEM_CTRL_IRQ | DEBUG_UNIT_IRQ | SYS_TIMER_IRQ
                    | RTC_IRQ | POWER_MGR_IRQ;
    s_nxt.irq_src = src;
    // gate control for ungated indices is forced off
    s_nxt.clk_en  = CLOCK_GATE_REQ & ~sad_pkg::NO_GATE_MASK;
    // reset wins over every request and command taken on the same edge;
    // the boot choice keeps following the pin until reset is released
    if (!RESETN) begin
      s_nxt.remap       = sad_pkg::REMAP_RST;
      // boot select is caught from the synchroniser while reset is held
      s_nxt.boot_rom    = s_r.bms_s2;
      s_nxt.sel_valid   = 1'b0;
      s_nxt.ext_cs      = 8'h00;
      s_nxt.rom_sel     = 1'b0;
      s_nxt.sram_sel    = 1'b0;
      s_nxt.usb_sel     = 1'b0;
      s_nxt.periph_sel  = 1'b0;
      s_nxt.abort       = 1'b0;
      s_nxt.target_addr = 32'h0000_0000;
      s_nxt.sys_irq     = 1'b0;
      s_nxt.irq_src     = 32'h0000_0000;
      s_nxt.clk_en      = 32'h0000_0000;
    end
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************

  // single synchronous state register; reset lives in s_nxt, so no flop
  // needs a reset pin and every flop sees the same clean clock edge
  always_ff @(posedge SYS_CLK) begin
    s_r <= s_nxt;
  end

  // decode answer
  assign SEL_VALID                 = s_r.sel_valid;
  assign EXT_CHIP_SELECT           = s_r.ext_cs;
  assign ROM_SELECT                = s_r.rom_sel;
  assign SRAM_SELECT               = s_r.sram_sel;
  assign USB_HOST_SELECT           = s_r.usb_sel;
  assign PERIPH_SELECT             = s_r.periph_sel;
  assign ABORT                     = s_r.abort;
  assign TARGET_ADDR               = s_r.target_addr;

  // boot map state
  assign REMAP_STATE               = s_r.remap;
  assign BOOT_FROM_ROM             = s_r.boot_rom;

  // interrupt and clock gate map
  assign COMBINED_SYSTEM_INTERRUPT = s_r.sys_irq;
  assign INTERRUPT_SOURCES         = s_r.irq_src;
  assign PERIPH_CLOCK_ENABLE       = s_r.clk_en;

endmodule : sad_decoder

// [shared/sad_pkg.sv]
/*
  Constants for the system address decoder: region split, internal memory
  windows, fixed bases and sizes, interrupt source indices, clock gate mask.
  Assumes a 32-bit byte address and a 32-entry interrupt/clock-gate map.
*/
package sad_pkg;

  // ****************************************************************
  // address decode
  // ****************************************************************
  localparam int          REGION_MSB      = 31;
  localparam int          REGION_LSB      = 28;
  localparam logic [3:0]  REGION_INTERNAL = 4'h0;
  localparam logic [3:0]  REGION_EXT_LO   = 4'h1;
  localparam logic [3:0]  REGION_EXT_HI   = 4'h8;
  localparam logic [3:0]  REGION_PERIPH   = 4'hF;
  localparam int          WIN_MSB         = 27;
  localparam int          WIN_LSB         = 20;
  localparam logic [7:0]  WIN_ALIAS       = 8'h00;
  localparam logic [7:0]  WIN_ROM         = 8'h01;
  localparam logic [7:0]  WIN_SRAM        = 8'h02;
  localparam logic [7:0]  WIN_USB_HOST    = 8'h03;
  localparam logic [31:0] ROM_BASE        = 32'h0010_0000;
  localparam logic [31:0] SRAM_BASE       = 32'h0020_0000;
  localparam logic [19:0] ROM_SIZE        = 20'h2_0000;
  localparam logic [19:0] SRAM_SIZE       = 20'h0_4000;

  // ****************************************************************
  // interrupt source / clock gate indices
  // ****************************************************************
  localparam int          IDX_FAST        = 0;
  localparam int          IDX_SYSTEM      = 1;
  localparam int          IDX_PARALLEL_IO = 2;
  localparam int          IDX_SERIAL      = 6;
  localparam int          IDX_CARD        = 10;
  localparam int          IDX_USB_DEVICE  = 11;
  localparam int          IDX_TWO_WIRE    = 12;
  localparam int          IDX_SPI         = 13;
  localparam int          IDX_SYNC_SERIAL = 14;
  localparam int          IDX_TIMER       = 17;
  localparam int          IDX_USB_HOST    = 23;
  localparam int          IDX_ETHERNET    = 24;
  localparam int          IDX_EXTERNAL    = 25;
  localparam logic [31:0] NO_GATE_MASK    = 32'hFE00_0003;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic        REMAP_RST       = 1'b0;

  typedef enum logic [2:0] {
    TGT_NONE   = 3'b000,
    TGT_EXT    = 3'b001,
    TGT_ROM    = 3'b010,
    TGT_SRAM   = 3'b011,
    TGT_USB    = 3'b100,
    TGT_PERIPH = 3'b101,
    TGT_ABORT  = 3'b110
  } sad_target_e;

endpackage : sad_pkg

// [tb/sad_decoder_asserts.sv]
/*
  Assertion checker for sad_decoder: decode answers, aliases, remap flag.
  Bound to every sad_decoder; sees only its top-level ports.
*/
`timescale 1ns/10ps
module sad_decoder_asserts (
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic        REQ_VALID,
  input wire logic [31:0] REQ_ADDR,
  input wire logic        REMAP_CMD,
  input wire logic        SEL_VALID,
  input wire logic [7:0]  EXT_CHIP_SELECT,
  input wire logic        ROM_SELECT,
  input wire logic        SRAM_SELECT,
  input wire logic        USB_HOST_SELECT,
  input wire logic        PERIPH_SELECT,
  input wire logic        ABORT,
  input wire logic [31:0] TARGET_ADDR,
  input wire logic        REMAP_STATE,
  input wire logic        BOOT_FROM_ROM,
  input wire logic        COMBINED_SYSTEM_INTERRUPT,
  input wire logic [31:0] INTERRUPT_SOURCES,
  input wire logic [31:0] PERIPH_CLOCK_ENABLE
);
  // ******************************************************************
  // relations, answers one cycle after the taking edge
  // ******************************************************************
  wire logic [3:0]  region = REQ_ADDR[31:28];
  wire logic [12:0] sels = {EXT_CHIP_SELECT, ROM_SELECT, SRAM_SELECT, USB_HOST_SELECT,
                            PERIPH_SELECT, ABORT};
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  answer_a: assert property (REQ_VALID |=> SEL_VALID && $onehot(sels))
    else $error("decode answer missing or not one-hot");
  idle_a: assert property (!REQ_VALID |=> !SEL_VALID && sels == 13'h0)
    else $error("select without request");
  ext_cs_a: assert property (REQ_VALID && region inside {[1:8]}
    |=> EXT_CHIP_SELECT == 8'h01 << ($past(region) - 4'h1)) else $error("wrong chip select");
  abort_a: assert property (REQ_VALID && region inside {[9:14]} |=> ABORT)
    else $error("unused region not aborted");
  periph_a: assert property (REQ_VALID && region == 4'hF
    |=> PERIPH_SELECT && TARGET_ADDR == $past(REQ_ADDR)) else $error("peripheral decode");
  rom_a: assert property (REQ_VALID && REQ_ADDR[31:17] == 15'h0008 |=> ROM_SELECT)
    else $error("rom fixed base");
  sram_alias_a: assert property (REQ_VALID && REQ_ADDR[31:14] == 18'h0 && REMAP_STATE
    |=> SRAM_SELECT && TARGET_ADDR == (sad_pkg::SRAM_BASE | $past(REQ_ADDR)))
    else $error("sram alias after remap");
  boot_alias_a: assert property (REQ_VALID && REQ_ADDR[31:17] == 15'h0 && !REMAP_STATE
    |=> ROM_SELECT == BOOT_FROM_ROM && ABORT == !BOOT_FROM_ROM) else $error("boot alias");
  remap_a: assert property (REMAP_CMD || REMAP_STATE |=> REMAP_STATE)
    else $error("remap flag not set or lost");
  sys_line_a: assert property (COMBINED_SYSTEM_INTERRUPT |=> INTERRUPT_SOURCES[1])
    else $error("system line not on index 1");
  no_gate_a: assert property ((PERIPH_CLOCK_ENABLE & 32'hFE00_0003) == 32'h0)
    else $error("ungated index has clock enable");

  cover property (REQ_VALID && REMAP_CMD);
  cover property (SEL_VALID && ABORT);
  cover property (COMBINED_SYSTEM_INTERRUPT);
endmodule : sad_decoder_asserts

bind sad_decoder sad_decoder_asserts i_chk (.SYS_CLK, .RESETN, .REQ_VALID, .REQ_ADDR,
  .REMAP_CMD, .SEL_VALID, .EXT_CHIP_SELECT, .ROM_SELECT, .SRAM_SELECT, .USB_HOST_SELECT,
  .PERIPH_SELECT, .ABORT, .TARGET_ADDR, .REMAP_STATE, .BOOT_FROM_ROM,
  .COMBINED_SYSTEM_INTERRUPT, .INTERRUPT_SOURCES, .PERIPH_CLOCK_ENABLE);

// [tb/sad_target_model.sv]
/*
  Far-side target model: each target claims its own select line.
  Assumes selects come straight from the decoder and are sampled settled.
*/
`timescale 1ns/10ps
module sad_target_model (
  input  wire logic        sel_valid,
  input  wire logic [7:0]  ext_cs,
  input  wire logic        rom_sel,
  input  wire logic        sram_sel,
  input  wire logic        usb_sel,
  input  wire logic        periph_sel,
  input  wire logic        abort,
  output sad_pkg::sad_target_e tgt,
  output logic             clash
);
  // ******************************************************************
  // target claim
  // ******************************************************************
  // a select without valid, or two claimants, is a clash
  always_comb begin
    tgt = sad_pkg::TGT_NONE;
    if (|ext_cs) tgt = sad_pkg::TGT_EXT;
    if (rom_sel) tgt = sad_pkg::TGT_ROM;
    if (sram_sel) tgt = sad_pkg::TGT_SRAM;
    if (usb_sel) tgt = sad_pkg::TGT_USB;
    if (periph_sel) tgt = sad_pkg::TGT_PERIPH;
    if (abort) tgt = sad_pkg::TGT_ABORT;
    clash = $countones({ext_cs, rom_sel, sram_sel, usb_sel, periph_sel, abort}) != 32'(sel_valid);
  end
endmodule : sad_target_model

// [tb/testbench.sv]
/*
  Testbench for sad_decoder: regions, internal windows, remap, reset with
  boot select low, interrupt index map and clock gate mask.
  Needs sad_pkg, the target model and the bound checker.
*/
`timescale 1ns/10ps
module testbench;
  // ******************************************************************
  // stimulus, design and far-side model
  // ******************************************************************
  logic                 sys_clk, resetn, req_valid, remap_cmd, boot_sel, sel_valid;
  logic [31:0]          req_addr, src, gate_req, taddr, int_src, clk_en;
  logic [4:0]           sys_irq;
  logic [7:0]           ext_cs;
  logic                 rom_sel, sram_sel, usb_sel, per_sel, abort;
  logic                 remap_st, boot_rom, sys_int, clash;
  sad_pkg::sad_target_e tgt;
  int                   fail_count, check_count;

  sad_decoder i_dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_ADDR(req_addr),
    .REMAP_CMD(remap_cmd), .BOOT_MEMORY_SELECT(boot_sel), .MEM_CTRL_IRQ(sys_irq[0]),
    .DEBUG_UNIT_IRQ(sys_irq[1]), .SYS_TIMER_IRQ(sys_irq[2]), .RTC_IRQ(sys_irq[3]),
    .POWER_MGR_IRQ(sys_irq[4]), .FAST_INTERRUPT(src[0]), .EXTERNAL_INTERRUPT(src[31:25]),
    .PARALLEL_IO_IRQ(src[5:2]), .SERIAL_PORT_IRQ(src[9:6]), .CARD_INTERFACE_IRQ(src[10]),
    .USB_DEVICE_IRQ(src[11]), .TWO_WIRE_IRQ(src[12]), .SPI_IRQ(src[13]),
    .SYNC_SERIAL_IRQ(src[16:14]), .TIMER_CHANNEL_IRQ(src[22:17]), .USB_HOST_IRQ(src[23]),
    .ETHERNET_IRQ(src[24]), .CLOCK_GATE_REQ(gate_req), .SEL_VALID(sel_valid),
    .EXT_CHIP_SELECT(ext_cs), .ROM_SELECT(rom_sel), .SRAM_SELECT(sram_sel),
    .USB_HOST_SELECT(usb_sel), .PERIPH_SELECT(per_sel), .ABORT(abort), .TARGET_ADDR(taddr),
    .REMAP_STATE(remap_st), .BOOT_FROM_ROM(boot_rom), .COMBINED_SYSTEM_INTERRUPT(sys_int),
    .INTERRUPT_SOURCES(int_src), .PERIPH_CLOCK_ENABLE(clk_en));
  sad_target_model i_tgt (.sel_valid(sel_valid), .ext_cs(ext_cs), .rom_sel(rom_sel),
    .sram_sel(sram_sel), .usb_sel(usb_sel), .periph_sel(per_sel), .abort(abort),
    .tgt(tgt), .clash(clash));

  // 8 ns clock; inputs move 1 ns after each rising edge
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic final_report;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // reset 16 cycles; a mid-run reset must also clear the remap flag
  task automatic do_reset(input logic boot);
    resetn = 1'b0;
    boot_sel = boot;
    req_valid = 1'b0;
    remap_cmd = 1'b0;
    tick(16);
    check(32'(remap_st), 32'h0);
    check(32'(boot_rom), 32'(boot));
    resetn = 1'b1;
  endtask : do_reset

  // request held high back to back; answer judged one edge later
  task automatic send(input logic [31:0] a, input sad_pkg::sad_target_e code,
                      input logic [31:0] ta);
    req_valid = 1'b1;
    req_addr = a;
    tick(1);
    check(32'(tgt), 32'(code));
    check(32'(clash), 32'h0);
    if (code != sad_pkg::TGT_ABORT) check(taddr, ta);
  endtask : send

  task automatic scen_regions;
    logic [31:0]          a;
    sad_pkg::sad_target_e code;
    for (int r = 1; r < 16; r++) begin
      a = {4'(r), 28'h0ABCDE4};
      code = r < 9 ? sad_pkg::TGT_EXT : r < 15 ? sad_pkg::TGT_ABORT : sad_pkg::TGT_PERIPH;
      send(a, code, a);
      check(32'(ext_cs), r < 9 ? 32'h1 << (r - 1) : 32'h0);
    end
    req_valid = 1'b0;
    tick(1);
    check(32'(sel_valid), 32'h0);
  endtask : scen_regions

  // boot from rom, then remap taken on the same edge as a request
  task automatic scen_internal;
    send(32'h0000_0010, sad_pkg::TGT_ROM, 32'h0010_0010);
    send(32'h0001_FFFC, sad_pkg::TGT_ROM, 32'h0011_FFFC);
    send(32'h0002_0000, sad_pkg::TGT_ABORT, 32'h0);
    send(32'h0011_FFFC, sad_pkg::TGT_ROM, 32'h0011_FFFC);
    send(32'h0012_0000, sad_pkg::TGT_ABORT, 32'h0);
    send(32'h0020_3FFC, sad_pkg::TGT_SRAM, 32'h0020_3FFC);
    send(32'h0020_4000, sad_pkg::TGT_ABORT, 32'h0);
    send(32'h003F_FFFC, sad_pkg::TGT_USB, 32'h003F_FFFC);
    send(32'h0040_0000, sad_pkg::TGT_ABORT, 32'h0);
    remap_cmd = 1'b1;
    send(32'h0000_0100, sad_pkg::TGT_ROM, 32'h0010_0100);
    remap_cmd = 1'b0;
    send(32'h0000_3FFC, sad_pkg::TGT_SRAM, 32'h0020_3FFC);
    send(32'h0000_4000, sad_pkg::TGT_ABORT, 32'h0);
    send(32'h0020_0100, sad_pkg::TGT_SRAM, 32'h0020_0100);
    send(32'h0010_0000, sad_pkg::TGT_ROM, 32'h0010_0000);
    req_valid = 1'b0;
    check(32'(remap_st), 32'h1);
    do_reset(1'b0);
    send(32'h0000_0000, sad_pkg::TGT_ABORT, 32'h0);
    send(32'h0010_0000, sad_pkg::TGT_ROM, 32'h0010_0000);
    req_valid = 1'b0;
  endtask : scen_internal

  // pins lag three edges, system lines two, other on-chip sources one; gates follow the same index
  task automatic scen_irq;
    logic pin;
    for (int i = 0; i < 5; i++) begin
      sys_irq = 5'h01 << i;
      tick(1);
      check(32'(sys_int), 32'h1);
      sys_irq = 5'h00;
      tick(1);
      check(int_src, 32'h0000_0002);
      check(32'(sys_int), 32'h0);
    end
    for (int i = 0; i < 32; i++) begin
      pin = (i == 0 || i > 24);
      src = (i == 1) ? 32'h0 : 32'h1 << i;
      gate_req = 32'h1 << i;
      tick(1);
      check(clk_en, (pin || i == 1) ? 32'h0 : gate_req);
      check(int_src, pin ? 32'h0 : src);
      if (pin) tick(2);
      check(int_src, src);
      src = 32'h0;
      gate_req = 32'h0;
      tick(3);
    end
  endtask : scen_irq

  initial begin
    {resetn, req_valid, remap_cmd, boot_sel} = 4'h0;
    {req_addr, src, gate_req} = 96'h0;
    sys_irq = 5'h00;
    tick(1);
    do_reset(1'b1);
    scen_regions();
    scen_internal();
    scen_irq();
    final_report();
  end

  // cuts a hang short
  initial begin
    #400000;
    fail_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    final_report();
  end
endmodule : testbench
